// ### include/sbc_pkg.sv
// Shared constants, register map and helpers of the serial baud and control block.
package sbc_pkg;

	// Widths of the reload value, the register port and the event set.
	localparam int unsigned RELOAD_W = 15;
	localparam int unsigned DATA_W   = 16;
	localparam int unsigned ADDR_W   = 5;
	localparam int unsigned EVT_W    = 3;

	// Clock rate of the bus clock that the reload counters divide.
	localparam int unsigned CLK_HZ = 50000000;

	// Register byte addresses, one aligned word each.
	localparam logic [4:0] OFF_CTRL    = 5'h00;
	localparam logic [4:0] OFF_BAUD    = 5'h04;
	localparam logic [4:0] OFF_CFG     = 5'h08;
	localparam logic [4:0] OFF_IRQ_STS = 5'h0c;
	localparam logic [4:0] OFF_IRQ_MSK = 5'h10;

	// Field positions of serial_control; bits 14:8 are stored, bit 15 is a strobe.
	localparam int unsigned CTRL_CLEAR_BIT = 15;
	localparam int unsigned CTRL_LSB       = 8;
	localparam int unsigned CTRL_MSB       = 14;
	localparam int unsigned CTL_SLAVE      = 6;
	localparam int unsigned CTL_SPI        = 5;
	localparam int unsigned CTL_RX_IRQ     = 4;
	localparam int unsigned CTL_TX_IRQ     = 3;
	localparam int unsigned CTL_TX_IDLE    = 2;
	localparam int unsigned CTL_RX_EN      = 1;
	localparam int unsigned CTL_TX_EN      = 0;

	// Field position of the configuration register.
	localparam int unsigned CFG_INV_BIT = 0;

	// Event positions in the interrupt status and mask registers.
	localparam int unsigned EVT_TX_WRAP = 0;
	localparam int unsigned EVT_RX_WRAP = 1;
	localparam int unsigned EVT_CLEAR   = 2;

	// Reset values.
	localparam logic [6:0]          CTRL_RESET = 7'h00;
	localparam logic                CFG_RESET  = 1'h0;
	localparam logic [RELOAD_W-1:0] BAUD_RESET = 15'h0000;
	localparam logic [EVT_W-1:0]    MSK_RESET  = 3'h0;

	// Level of the serial clock in the long or short phase of a period.
	function automatic logic sclk_level(input logic long_ph, input logic spi, input logic inv);
		return long_ph ? (spi == inv) : (spi != inv);
	endfunction

endpackage

// ### include/sbc_gen_if.sv
// Link between the control logic and one reload counter.
interface sbc_gen_if #(parameter int unsigned W = 15);
	logic [W-1:0] reload;
	logic         restart;
	logic         run;
	logic         phase_a;
	logic         wrap;

	modport ctl (output reload, output restart, output run, input phase_a, input wrap);
	modport cnt (input reload, input restart, input run, output phase_a, output wrap);
endinterface

// ### core/sbc_reload_counter.sv
// One reload counter that divides the bus clock into a serial clock phase.
module sbc_reload_counter #(
	parameter int unsigned W = 15
) (
	input wire logic clock_in, // Bus clock.
	input wire logic nrst_in,  // Synchronous reset, active low.
	sbc_gen_if.cnt   gen       // Reload value, restart, run, phase and wrap.
);

	if (W < 2 || W > 16) begin : g_width_check
		$error("reload width must be 2 to 16");
	end

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic         phase_ff;
	logic         nxt_phase;
	logic         wrap_ff;
	logic         nxt_wrap;
	logic         active;
	logic         at_zero;

	// True while the count sits in the longer, first part of the period.
	function automatic logic in_long_phase(input logic [W-1:0] c, input logic [W-1:0] v);
		return c >= ((v >> 1) + W'(v[0]));
	endfunction

	// A zero reload value parks the counter so no serial clock is made.
	assign active    = gen.run && (gen.reload != '0);
	assign at_zero   = (cnt_ff == '0);
	// Count down to zero, then reload; restart loads the value at once.
	assign nxt_cnt   = (gen.restart || !active || at_zero) ? gen.reload : cnt_ff - W'(1);
	assign nxt_wrap  = active && !gen.restart && at_zero;
	// Ceiling of half the value splits the period so only even values skew it.
	assign nxt_phase = in_long_phase(nxt_cnt, gen.reload);

	// Counter state.
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			cnt_ff   <= '0;
			phase_ff <= 1'b1;
			wrap_ff  <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			phase_ff <= nxt_phase;
			wrap_ff  <= nxt_wrap;
		end
	end

	assign gen.phase_a = phase_ff;
	assign gen.wrap    = wrap_ff;

	// Helper counters that measure period and long-phase length for the checks.
	logic [W-1:0] gap_ff;
	logic         gap_ok_ff;
	logic [W-1:0] len_ff;
	logic         len_ok_ff;

	always_ff @(posedge clock_in) begin
		if (!nrst_in || gen.restart || !active) begin
			gap_ff    <= '0;
			gap_ok_ff <= 1'b0;
			len_ff    <= '0;
			len_ok_ff <= 1'b0;
		end else begin
			gap_ff    <= wrap_ff ? '0 : gap_ff + W'(1);
			gap_ok_ff <= gap_ok_ff || wrap_ff;
			len_ff    <= phase_ff ? len_ff + W'(1) : '0;
			len_ok_ff <= len_ok_ff || wrap_ff;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);

	a_period_span: assert property (wrap_ff && gap_ok_ff && !gen.restart |-> gap_ff == gen.reload)
		else $error("serial period is not reload plus one bus clocks");
	a_long_phase: assert property ($fell(phase_ff) && len_ok_ff && $stable(gen.reload) && active
		|-> len_ff == (gen.reload >> 1) + W'(1))
		else $error("long phase length is wrong");
	a_stop_no_wrap: assert property ((gen.reload == '0) |=> !wrap_ff)
		else $error("counter wrapped with a zero reload value");

endmodule

// ### core/sbc_irq_status.sv
// Sticky event flags, their mask and the single level interrupt.
module sbc_irq_status #(
	parameter int unsigned N = 3
) (
	input  wire logic         clock_in,   // Bus clock.
	input  wire logic         nrst_in,    // Synchronous reset, active low.
	input  wire logic [N-1:0] event_in,   // One-cycle event pulses.
	input  wire logic         sts_we_in,  // Write to status: ones clear.
	input  wire logic         msk_we_in,  // Write to mask.
	input  wire logic [N-1:0] wdata_in,   // Write data.
	output logic      [N-1:0] status_out, // Sticky flags.
	output logic      [N-1:0] mask_out,   // Mask, one enables.
	output logic              irq_out     // High while an enabled flag is set.
);

	if (N < 1 || N > 16) begin : g_width_check
		$error("event count must be 1 to 16");
	end

	logic [N-1:0] sts_ff;
	logic [N-1:0] msk_ff;
	logic         irq_ff;
	logic [N-1:0] nxt_sts;
	logic [N-1:0] nxt_msk;

	// The event is ORed in after the clear so a set in the clearing cycle wins.
	assign nxt_sts = (sts_ff & ~(sts_we_in ? wdata_in : '0)) | event_in;
	assign nxt_msk = msk_we_in ? wdata_in : msk_ff;

	// Flags, mask and the interrupt computed from next values so all agree.
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			sts_ff <= '0;
			msk_ff <= sbc_pkg::MSK_RESET;
			irq_ff <= 1'b0;
		end else begin
			sts_ff <= nxt_sts;
			msk_ff <= nxt_msk;
			irq_ff <= |(nxt_sts & nxt_msk);
		end
	end

	assign status_out = sts_ff;
	assign mask_out   = msk_ff;
	assign irq_out    = irq_ff;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);

	a_set_wins_clear: assert property (sts_we_in && |(event_in & wdata_in) |=> |(sts_ff & $past(event_in)))
		else $error("event lost in the clearing cycle");
	a_irq_tracks_flags: assert property (irq_ff == |(sts_ff & msk_ff))
		else $error("interrupt disagrees with flags and mask");

endmodule

// ### core/sbc_top.sv
// Baud-rate generator and serial control register of the clocked serial port.
module sbc_top (
	input  wire logic        clock_in,            // Bus clock, 50 MHz.
	input  wire logic        nrst_in,             // Synchronous reset, active low.
	input  wire logic [4:0]  addr_in,             // Register byte address.
	input  wire logic [15:0] wdata_in,            // Write data.
	input  wire logic        wr_in,               // Write strobe.
	input  wire logic        rd_in,               // Read strobe.
	output logic      [15:0] rdata_out,           // Read data, the cycle after rd_in.
	input  wire logic        sck_in,              // Serial clock pin input.
	output logic             sck_out,             // Serial clock pin output.
	output logic             sck_oe_out,          // Serial clock pin drive enable.
	output logic             rx_sclk_out,         // Internal receive sampling clock.
	output logic             soft_reset_out,      // One-cycle pulse: abort and reset sources.
	output logic             cs_inactive_out,     // One-cycle pulse: all chip selects inactive.
	output logic             slave_mode_out,      // Slave mode selected.
	output logic             spi_mode_out,        // SPI-style transfer selected.
	output logic             clock_invert_out,    // Idle-low clock format.
	output logic             rx_irq_enable_out,   // Receive interrupt enable.
	output logic             tx_irq_enable_out,   // Transmit interrupt enable.
	output logic             tx_idle_irq_enable_out, // Transmit idle interrupt enable.
	output logic             rx_enable_out,       // Receive enable.
	output logic             tx_enable_out,       // Transmit enable.
	output logic             irq_out              // Block interrupt, level.
);

	localparam int unsigned W = sbc_pkg::RELOAD_W;
	localparam int unsigned E = sbc_pkg::EVT_W;

	// Stored registers.
	logic [6:0]          ctrl_ff;
	logic                inv_ff;
	logic [W-1:0]        baud_ff;
	logic [15:0]         rdata_ff;
	logic                clear_ff;
	logic                cs_idle_ff;
	logic                sck_s1_ff;
	logic                sck_s2_ff;
	logic                tx_sclk_ff;
	logic                rx_sclk_ff;
	logic                sck_oe_ff;

	// Decode of the register port.
	logic                wr_ctrl;
	logic                wr_baud;
	logic                wr_cfg;
	logic                wr_sts;
	logic                wr_msk;
	logic                clear_req;
	logic [W-1:0]        reload_now;
	logic                slave;
	logic                spi;
	logic                tx_active;
	logic                rx_active;
	logic                idle_lvl;
	logic                nxt_tx_sclk;
	logic                nxt_rx_sclk;
	logic [15:0]         rd_mux;
	logic [E-1:0]        events;
	logic [E-1:0]        irq_sts;
	logic [E-1:0]        irq_msk;

	assign wr_ctrl   = wr_in && (addr_in == sbc_pkg::OFF_CTRL);
	assign wr_baud   = wr_in && (addr_in == sbc_pkg::OFF_BAUD);
	assign wr_cfg    = wr_in && (addr_in == sbc_pkg::OFF_CFG);
	assign wr_sts    = wr_in && (addr_in == sbc_pkg::OFF_IRQ_STS);
	assign wr_msk    = wr_in && (addr_in == sbc_pkg::OFF_IRQ_MSK);
	// Only a one in bit 15 acts; a zero there is simply dropped.
	assign clear_req = wr_ctrl && wdata_in[sbc_pkg::CTRL_CLEAR_BIT];

	// Mode terms used by both clock paths.
	assign slave     = ctrl_ff[sbc_pkg::CTL_SLAVE];
	assign spi       = ctrl_ff[sbc_pkg::CTL_SPI];
	assign idle_lvl  = ~inv_ff;
	// The generators only run in master mode; slave mode bypasses them.
	assign tx_active = !slave && ctrl_ff[sbc_pkg::CTL_TX_EN] && (baud_ff != '0);
	assign rx_active = !slave && ctrl_ff[sbc_pkg::CTL_RX_EN] && (baud_ff != '0);

	// Two counters sharing one reload value, restarted by a reload write or a clear.
	sbc_gen_if #(.W(W)) tx_gen ();
	sbc_gen_if #(.W(W)) rx_gen ();

	// A reload write reaches the counters in its own cycle, so they start from the new value, not the old one.
	assign reload_now     = wr_baud ? wdata_in[W-1:0] : baud_ff;
	assign tx_gen.reload  = reload_now;
	assign rx_gen.reload  = reload_now;
	assign tx_gen.restart = wr_baud || clear_req;
	assign rx_gen.restart = wr_baud || clear_req;
	assign tx_gen.run     = tx_active;
	assign rx_gen.run     = rx_active;

	sbc_reload_counter #(.W(W)) u_tx_cnt (
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.gen      (tx_gen)
	);

	sbc_reload_counter #(.W(W)) u_rx_cnt (
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.gen      (rx_gen)
	);

	// Long phase level depends on transfer style and clock format.
	assign nxt_tx_sclk = slave ? sck_s2_ff :
		(tx_active ? sbc_pkg::sclk_level(tx_gen.phase_a, spi, inv_ff) : idle_lvl);
	assign nxt_rx_sclk = slave ? sck_s2_ff :
		(rx_active ? sbc_pkg::sclk_level(rx_gen.phase_a, spi, inv_ff) : idle_lvl);

	// Counter wraps and the clear itself are the interrupt events.
	assign events = {clear_ff, rx_gen.wrap, tx_gen.wrap};

	sbc_irq_status #(.N(E)) u_irq (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.event_in   (events),
		.sts_we_in  (wr_sts),
		.msk_we_in  (wr_msk),
		.wdata_in   (wdata_in[E-1:0]),
		.status_out (irq_sts),
		.mask_out   (irq_msk),
		.irq_out    (irq_out)
	);

	// Read selection; the clear bit and unmapped addresses read as zero.
	always_comb begin
		unique case (addr_in)
			sbc_pkg::OFF_CTRL:    rd_mux = {1'b0, ctrl_ff, 8'h00};
			sbc_pkg::OFF_BAUD:    rd_mux = {1'b0, baud_ff};
			sbc_pkg::OFF_CFG:     rd_mux = {15'h0000, inv_ff};
			sbc_pkg::OFF_IRQ_STS: rd_mux = {13'h0000, irq_sts};
			sbc_pkg::OFF_IRQ_MSK: rd_mux = {13'h0000, irq_msk};
			default:              rd_mux = 16'h0000;
		endcase
	end

	// Software registers; a clear keeps the reload and format values, while its own write loads control bits 14:8.
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			ctrl_ff <= sbc_pkg::CTRL_RESET;
			inv_ff  <= sbc_pkg::CFG_RESET;
			baud_ff <= sbc_pkg::BAUD_RESET;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= wdata_in[sbc_pkg::CTRL_MSB:sbc_pkg::CTRL_LSB];
			if (wr_cfg)
				inv_ff <= wdata_in[sbc_pkg::CFG_INV_BIT];
			if (wr_baud)
				baud_ff <= wdata_in[W-1:0];
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge clock_in) begin
		if (!nrst_in)
			rdata_ff <= 16'h0000;
		else
			rdata_ff <= rd_in ? rd_mux : 16'h0000;
	end

	// Clear pulses go to the transfer, flag and chip-select logic outside.
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			clear_ff   <= 1'b0;
			cs_idle_ff <= 1'b0;
		end else begin
			clear_ff   <= clear_req;
			cs_idle_ff <= clear_req;
		end
	end

	// The pin clock is asynchronous; only the second stage feeds logic.
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			sck_s1_ff <= 1'b1;
			sck_s2_ff <= 1'b1;
		end else begin
			sck_s1_ff <= sck_in;
			sck_s2_ff <= sck_s1_ff;
		end
	end

	// Serial clock outputs and pin direction; reset parks them at the idle level.
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			tx_sclk_ff <= 1'b1;
			rx_sclk_ff <= 1'b1;
			sck_oe_ff  <= 1'b0;
		end else begin
			tx_sclk_ff <= nxt_tx_sclk;
			rx_sclk_ff <= nxt_rx_sclk;
			sck_oe_ff  <= !slave;
		end
	end

	assign rdata_out              = rdata_ff;
	assign sck_out                = tx_sclk_ff;
	assign sck_oe_out             = sck_oe_ff;
	assign rx_sclk_out            = rx_sclk_ff;
	assign soft_reset_out         = clear_ff;
	assign cs_inactive_out        = cs_idle_ff;
	assign slave_mode_out         = ctrl_ff[sbc_pkg::CTL_SLAVE];
	assign spi_mode_out           = ctrl_ff[sbc_pkg::CTL_SPI];
	assign clock_invert_out       = inv_ff;
	assign rx_irq_enable_out      = ctrl_ff[sbc_pkg::CTL_RX_IRQ];
	assign tx_irq_enable_out      = ctrl_ff[sbc_pkg::CTL_TX_IRQ];
	assign tx_idle_irq_enable_out = ctrl_ff[sbc_pkg::CTL_TX_IDLE];
	assign rx_enable_out          = ctrl_ff[sbc_pkg::CTL_RX_EN];
	assign tx_enable_out          = ctrl_ff[sbc_pkg::CTL_TX_EN];

	// Checks on the behaviour of the block as seen at its ports.
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);

	sequence s_ctrl_wr_rd;
		wr_ctrl ##1 (rd_in && addr_in == sbc_pkg::OFF_CTRL);
	endsequence

	sequence s_master_restart;
		(wr_baud || clear_req)
			##1 (!wr_ctrl && tx_active);
	endsequence

	sequence s_rx_restart;
		(wr_baud || clear_req)
			##1 (!wr_ctrl && rx_active);
	endsequence

	sequence s_baud_wr_rd;
		wr_baud ##1 (rd_in && addr_in == sbc_pkg::OFF_BAUD);
	endsequence

	sequence s_cfg_wr_rd;
		wr_cfg ##1 (rd_in && addr_in == sbc_pkg::OFF_CFG);
	endsequence

	a_clear_reads_zero: assert property (rd_in && addr_in == sbc_pkg::OFF_CTRL |=> !rdata_ff[15])
		else $error("clear bit did not read zero");
	a_zero_write_inert: assert property (wr_ctrl && !wdata_in[15] |=> !clear_ff && !cs_idle_ff)
		else $error("writing zero to the clear bit acted");
	a_clear_pulses: assert property (clear_req |=> clear_ff && cs_idle_ff ##1 !clear_ff || $past(clear_req))
		else $error("clear did not pulse reset and chip-select outputs");
	a_restart_phase: assert property (s_master_restart
		|=> sck_out == sbc_pkg::sclk_level(1'b1, $past(spi), $past(inv_ff)))
		else $error("counter did not restart in the long phase");
	a_zero_stops: assert property ((baud_ff == '0 && !slave)[*2] |-> sck_out == !$past(inv_ff))
		else $error("serial clock moved with zero reload");
	a_idle_level: assert property ((!ctrl_ff[sbc_pkg::CTL_TX_EN] && !slave)[*2] |-> sck_out == !$past(inv_ff))
		else $error("serial clock not at its idle level");
	a_slave_direct: assert property (slave[*4] |-> sck_out == $past(sck_in, 3) && rx_sclk_out == $past(sck_in, 3))
		else $error("slave clock not taken from the pin");
	a_ctrl_readback: assert property (s_ctrl_wr_rd |=> rdata_ff[14:8] == $past(wdata_in[14:8], 2))
		else $error("control bits did not read back");
	a_pin_direction: assert property (slave |=> !sck_oe_out)
		else $error("clock pin driven in slave mode");

	// Checks of reads, register hold, restarts, pin drive and the clear; a slip here strands software silently.
	a_rdata_idle: assert property (!rd_in |=> rdata_ff == 16'h0000)
		else $error("read data stood without a read strobe");
	a_baud_readback: assert property (s_baud_wr_rd |=> rdata_ff == {1'b0, $past(wdata_in[W-1:0], 2)})
		else $error("reload value did not read back");
	a_cfg_readback: assert property (s_cfg_wr_rd
		|=> rdata_ff == {15'h0000, $past(wdata_in[sbc_pkg::CFG_INV_BIT], 2)})
		else $error("clock format did not read back");
	a_ctrl_stable: assert property (!wr_ctrl |=> $stable(ctrl_ff))
		else $error("control bits changed without a write");
	a_inv_stable: assert property (!wr_cfg |=> $stable(inv_ff))
		else $error("clock format changed without a write");
	a_regs_kept: assert property (clear_req |=> $stable(baud_ff) && $stable(inv_ff))
		else $error("clear disturbed a register");
	a_clear_restarts: assert property (clear_req |=> tx_gen.phase_a && rx_gen.phase_a)
		else $error("clear did not restart both counters");
	a_master_drive: assert property (!slave |=> sck_oe_out)
		else $error("clock pin not driven in master mode");
	a_rx_restart_phase: assert property (s_rx_restart
		|=> rx_sclk_out == sbc_pkg::sclk_level(1'b1, $past(spi), $past(inv_ff)))
		else $error("receive counter did not restart in the long phase");
	a_clear_event: assert property (clear_req |-> ##2 irq_sts[sbc_pkg::EVT_CLEAR])
		else $error("clear event flag not raised");
	a_slave_no_wrap: assert property (slave |=> !tx_gen.wrap && !rx_gen.wrap)
		else $error("generator ran in slave mode");

endmodule

// ### bench/sbc_far_peer.sv
// Far-side serial master that drives the clock pin while the block is a slave.
module sbc_far_peer (
	input  wire logic clock_in, // Bus clock, used only to pace the frame.
	input  wire logic go_in,    // One-cycle pulse that starts a frame.
	output logic      sck_out   // Serial clock towards the block.
);
	logic [4:0] edges_ff = 5'h00;
	logic [1:0] div_ff   = 2'h0;

	initial sck_out = 1'b1;

	// Sixteen toggles, three bus clocks apart; the line rests high between frames, as a pull-up would leave it.
	always @(posedge clock_in) begin
		if (go_in) begin
			edges_ff <= 5'h10;
			div_ff   <= 2'h0;
		end else if (edges_ff != 5'h00) begin
			if (div_ff == 2'h2) begin
				div_ff   <= 2'h0;
				sck_out  <= ~sck_out;
				edges_ff <= edges_ff - 5'h01;
			end else begin
				div_ff <= div_ff + 2'h1;
			end
		end
	end
endmodule

// ### bench/tb.sv
// Self-checking testbench of the serial baud generator and control register.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock_in = 1'b0;
	logic        nrst_in  = 1'b0;
	logic [4:0]  addr_in  = 5'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic        wr_in    = 1'b0;
	logic        rd_in    = 1'b0;
	logic        go       = 1'b0;
	logic [15:0] rdata_out;
	logic        sck_in, sck_out, sck_oe_out, rx_sclk_out, soft_reset_out, cs_inactive_out;
	logic [6:0]  ctl_o;
	logic        inv_o, irq_o;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles     = 0;
	logic [15:0] d;

	// Clock of 50 MHz.
	always #10 clock_in = ~clock_in;

	sbc_top DUT (.clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sck_in(sck_in), .sck_out(sck_out),
		.sck_oe_out(sck_oe_out), .rx_sclk_out(rx_sclk_out), .soft_reset_out(soft_reset_out),
		.cs_inactive_out(cs_inactive_out), .slave_mode_out(ctl_o[6]), .spi_mode_out(ctl_o[5]),
		.clock_invert_out(inv_o), .rx_irq_enable_out(ctl_o[4]), .tx_irq_enable_out(ctl_o[3]),
		.tx_idle_irq_enable_out(ctl_o[2]), .rx_enable_out(ctl_o[1]), .tx_enable_out(ctl_o[0]), .irq_out(irq_o));

	sbc_far_peer peer (.clock_in(clock_in), .go_in(go), .sck_out(sck_in));

	// Prints the counts and the verdict, then stops the run.
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// A hung handshake or wait must not stall the run forever.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clock_in);
		addr_in  <= a;
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge clock_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(negedge clock_in);
		v = rdata_out;
	endtask

	task automatic reset_values();
		rd(sbc_pkg::OFF_CTRL, d); chk(d, 16'h0000, "ctrl reset");
		rd(sbc_pkg::OFF_BAUD, d); chk(d, 16'h0000, "reload reset");
		rd(sbc_pkg::OFF_CFG, d); chk(d, 16'h0000, "config reset");
		rd(sbc_pkg::OFF_IRQ_MSK, d); chk(d, 16'h0000, "mask reset");
		rd(5'h14, d); chk(d, 16'h0000, "unmapped read");
		chk({15'h0000, sck_out}, 16'h0001, "idle high");
		chk({15'h0000, sck_oe_out}, 16'h0001, "master drives clock");
	endtask

	task automatic ctrl_access();
		wr(5'h14, 16'hffff);
		wr(sbc_pkg::OFF_CTRL, 16'h7f00);
		rd(sbc_pkg::OFF_CTRL, d); chk(d, 16'h7f00, "ctrl readback");
		chk({9'h000, ctl_o}, 16'h007f, "ctrl outputs set");
		wr(sbc_pkg::OFF_CTRL, 16'h0000);
		rd(sbc_pkg::OFF_CTRL, d); chk(d, 16'h0000, "ctrl cleared");
		chk({9'h000, ctl_o}, 16'h0000, "ctrl outputs cleared");
	endtask

	// Counts high samples of both generators over four periods and edges of the transmit clock over the same span.
	task automatic period(input logic spi, input logic inv, input logic [14:0] v);
		int hi, rhi, tr, p, lng, sht;
		logic prev, l;
		wr(sbc_pkg::OFF_CTRL, {2'b00, spi, 13'h0300});
		wr(sbc_pkg::OFF_CFG, {15'h0000, inv});
		wr(sbc_pkg::OFF_BAUD, {1'b0, v});
		repeat (10) @(posedge clock_in);
		hi = 0; rhi = 0; tr = 0; p = int'(v) + 1;
		lng = int'(v) / 2 + 1; sht = (int'(v) + 1) / 2;
		l = (spi == inv);
		for (int i = 0; i <= 4 * p; i++) begin
			@(negedge clock_in);
			if (i < 4 * p) begin
				hi += int'(sck_out);
				rhi += int'(rx_sclk_out);
			end
			if (i > 0 && sck_out !== prev) tr++;
			prev = sck_out;
		end
		chk(16'(tr), 16'h0008, "edges in four periods");
		chk(16'(hi), 16'(4 * (l ? lng : sht)), "high width");
		chk(16'(rhi), 16'(4 * (l ? lng : sht)), "rx high width");
	endtask

	task automatic stopped(input logic inv);
		wr(sbc_pkg::OFF_CTRL, 16'h0300);
		wr(sbc_pkg::OFF_CFG, {15'h0000, inv});
		wr(sbc_pkg::OFF_BAUD, 16'h0000);
		repeat (4) @(posedge clock_in);
		for (int i = 0; i < 20; i++) begin
			@(negedge clock_in);
			chk({14'h0000, sck_out, inv_o}, {14'h0000, ~inv, inv}, "stopped idle");
		end
	endtask

	// Even reload 6 restarted: long high phase of four cycles, then low.
	task automatic restart();
		wr(sbc_pkg::OFF_CTRL, 16'h0100);
		wr(sbc_pkg::OFF_CFG, 16'h0000);
		wr(sbc_pkg::OFF_BAUD, 16'h0005);
		repeat (7) @(posedge clock_in);
		wr(sbc_pkg::OFF_BAUD, 16'h0006);
		repeat (1) @(posedge clock_in);
		for (int i = 0; i < 4; i++) begin
			@(negedge clock_in);
			chk({15'h0000, sck_out}, 16'h0001, "restart long phase");
			@(posedge clock_in);
		end
		@(negedge clock_in);
		chk({15'h0000, sck_out}, 16'h0000, "restart short phase");
	endtask

	task automatic soft_clear();
		wr(sbc_pkg::OFF_IRQ_MSK, 16'h0000);
		wr(sbc_pkg::OFF_IRQ_STS, 16'h0007);
		// FIFO enables sit outside this block and never turn on here, so the clear meets that precondition.
		wr(sbc_pkg::OFF_CTRL, 16'h8100);
		@(negedge clock_in);
		chk({14'h0000, soft_reset_out, cs_inactive_out}, 16'h0003, "clear pulses");
		@(posedge clock_in);
		@(negedge clock_in);
		chk({14'h0000, soft_reset_out, cs_inactive_out}, 16'h0000, "pulses end");
		chk({15'h0000, sck_out}, 16'h0001, "clear restart");
		rd(sbc_pkg::OFF_CTRL, d); chk(d, 16'h0100, "ctrl kept, clear reads 0");
		rd(sbc_pkg::OFF_IRQ_STS, d); chk(d & 16'h0004, 16'h0004, "clear event");
		wr(sbc_pkg::OFF_CTRL, 16'h0100);
		repeat (2) begin
			@(negedge clock_in);
			chk({15'h0000, soft_reset_out}, 16'h0000, "zero write no clear");
		end
	endtask

	task automatic irq_path();
		wr(sbc_pkg::OFF_BAUD, 16'h0003);
		wr(sbc_pkg::OFF_IRQ_STS, 16'h0007);
		repeat (12) @(posedge clock_in);
		@(negedge clock_in);
		chk({15'h0000, irq_o}, 16'h0000, "masked irq");
		rd(sbc_pkg::OFF_IRQ_STS, d); chk(d & 16'h0001, 16'h0001, "wrap event");
		wr(sbc_pkg::OFF_IRQ_MSK, 16'h0001);
		repeat (2) @(posedge clock_in);
		@(negedge clock_in);
		chk({15'h0000, irq_o}, 16'h0001, "irq raised");
		wr(sbc_pkg::OFF_BAUD, 16'h0000);
		repeat (8) @(posedge clock_in);
		wr(sbc_pkg::OFF_IRQ_STS, 16'h0007);
		repeat (2) @(posedge clock_in);
		@(negedge clock_in);
		chk({15'h0000, irq_o}, 16'h0000, "irq cleared");
	endtask

	// In slave mode the pin clock passes straight through, three bus clocks late.
	task automatic slave_pass();
		logic [3:0] h;
		wr(sbc_pkg::OFF_CTRL, 16'h4200);
		wr(sbc_pkg::OFF_BAUD, 16'h0003);
		@(posedge clock_in);
		go <= 1'b1;
		@(posedge clock_in);
		go <= 1'b0;
		h = 4'hf;
		for (int i = 0; i < 60; i++) begin
			@(negedge clock_in);
			h = {h[2:0], sck_in};
			if (i >= 3) chk({14'h0000, sck_out, rx_sclk_out}, {14'h0000, h[3], h[3]}, "slave clock");
		end
		chk({15'h0000, sck_oe_out}, 16'h0000, "slave no drive");
	endtask

	initial begin
		repeat (16) @(posedge clock_in);
		nrst_in <= 1'b1;
		reset_values();
		ctrl_access();
		for (int k = 0; k < 4; k++) begin
			period(k[1], k[0], 15'h0003);
			period(k[1], k[0], 15'h0004);
		end
		stopped(1'b0);
		stopped(1'b1);
		restart();
		soft_clear();
		irq_path();
		slave_pass();
		conclude();
	end
endmodule
